/* File: rtl/vsf_pkg.sv */
// Constants, types and helpers of the voltage supervisor block.
// Assumes a 50 MHz ref_clk and classic Wishbone with 32-bit data.
//
// Behaviour
// - OV on an own regulator rail switches it off until the fault clears.
// - Supervision and flag reporting run only while failsafe_enable is 1.
// - Core monitor covers buck one, or buck one and two when multiphase.
// - Core OV impact: 00 none, 01 fail-safe, 1x fail-safe and reset.
// - Core UV impact: 00 none, 01 fail-safe (default), 1x both.
// - Core impact fields are written and accepted only in the init phase.
// - Core OV recognised after persisting 25 or 45 us, one-bit select.
// - Core UV recognised after persisting 5, 15, 25 or 40 us.
// - Core OV and UV thresholds come from 8-bit programmed codes.
// - Host writes 5-bit offset and its complement; 6.25 mV per count.
// - Core ramp starts only after a confirmed complement write.
// - A wrong complement skips scaling; core output stays unchanged.
// - Thresholds move to the scaled target at once on a good complement.
// - Scaling ramp finishes inside the core OV filter time.
// - 3-bit select names the I/O rail source; external never switched off.
// - I/O faults always apply their configured reset and fail-safe reaction.
// - I/O impact codes decode like core; defaults OV 1x, UV 01.
package vsf_pkg;

  // Clock and filter times
  localparam int CLK_PERIOD_NS = 20;
  localparam int OV_FILT_A_US  = 25;
  localparam int OV_FILT_B_US  = 45;
  localparam int UV_FILT_0_US  = 5;
  localparam int UV_FILT_1_US  = 15;
  localparam int UV_FILT_2_US  = 25;
  localparam int UV_FILT_3_US  = 40;
  localparam int RAMP_STEP_NS  = 1000;

  // Least times round up, the ramp step rounds down
  localparam logic [11:0] OV_A_CYC =
    12'((OV_FILT_A_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [11:0] OV_B_CYC =
    12'((OV_FILT_B_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [11:0] UV_0_CYC =
    12'((UV_FILT_0_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [11:0] UV_1_CYC =
    12'((UV_FILT_1_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [11:0] UV_2_CYC =
    12'((UV_FILT_2_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [11:0] UV_3_CYC =
    12'((UV_FILT_3_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [5:0]  RAMP_CYC =
    6'(RAMP_STEP_NS / CLK_PERIOD_NS);

  // Register byte offsets
  localparam logic [7:0] REG_IMPACT  = 8'h00;
  localparam logic [7:0] REG_VSC_OFF = 8'h04;
  localparam logic [7:0] REG_VSC_INV = 8'h08;
  localparam logic [7:0] REG_STATUS  = 8'h0c;
  localparam logic [7:0] REG_IRQ_ST  = 8'h10;
  localparam logic [7:0] REG_IRQ_MSK = 8'h14;

  // Monitor channel indices, impact field is bits 2*i+1:2*i
  localparam int MON_CORE_OV = 0;
  localparam int MON_CORE_UV = 1;
  localparam int MON_IO_OV   = 2;
  localparam int MON_IO_UV   = 3;
  localparam int MON_N       = 4;

  // Reset values and field limits
  localparam logic [7:0] IMPACT_RST  = 8'h66;
  localparam logic [4:0] OFF_RST     = 5'h00;
  localparam logic [4:0] INV_RST     = 5'h1f;
  localparam logic [4:0] OFF_MAX     = 5'h10;
  localparam logic [2:0] IO_SRC_EXT  = 3'h0;

  // Status and interrupt bit positions
  localparam int ST_BUSY  = 4;
  localparam int ST_INIT  = 5;
  localparam int ST_EN    = 6;
  localparam int ST_VOUT  = 8;
  localparam int ST_TH    = 16;
  localparam int IRQ_DONE = 4;
  localparam int IRQ_REJ  = 5;
  localparam int IRQ_W    = 6;

  typedef enum logic [0:0] {
    VSF_VSC_IDLE = 1'b0,
    VSF_VSC_RAMP = 1'b1
  } vsf_vsc_e;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } vsf_wb_req_s;

  typedef struct packed {
    logic       core_ov_filter_sel;
    logic [1:0] core_uv_filter_sel;
    logic       io_ov_filter_sel;
    logic [1:0] io_uv_filter_sel;
    logic [7:0] core_ov_threshold_code;
    logic [7:0] core_uv_threshold_code;
    logic [2:0] io_monitor_source_sel;
  } vsf_otp_s;

  typedef struct packed {
    logic [11:0] cnt;
    logic        out;
  } vsf_filt_s;

  function automatic logic [11:0] vsf_uv_cyc(input logic [1:0] sel);
    logic [11:0] r;
    case (sel)
      2'h0:    r = UV_0_CYC;
      2'h1:    r = UV_1_CYC;
      2'h2:    r = UV_2_CYC;
      default: r = UV_3_CYC;
    endcase
    return r;
  endfunction

endpackage

/* File: rtl/vsf_deglitch.sv */
// Persistence filter for one comparator level.
// Assumes the level is already synchronised to ref_clk.
`timescale 1ns/1ns
module vsf_deglitch (
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic        enable,
  input  wire logic        level,
  input  wire logic [11:0] limit,
  output logic             filtered
);

  vsf_pkg::vsf_filt_s s_reg;
  vsf_pkg::vsf_filt_s s_next;

  // Any drop restarts the count, so short glitches never pass
  always_comb begin
    s_next = s_reg;
    if (!enable || !level) begin
      s_next.cnt = 12'h000;
      s_next.out = 1'b0;
    end else if (s_reg.cnt != limit) begin
      s_next.cnt = s_reg.cnt + 12'h001;
    end
    s_next.out = enable && level && (s_next.cnt == limit);
  end

  // State register
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign filtered = s_reg.out;

endmodule

/* File: rtl/vsf_supervisor.sv */
// Voltage supervisor control: filters, reactions, scaling, registers.
// Assumes comparator levels arrive asynchronously from the analog side;
// fail-safe phase and enable come from logic on ref_clk.
`timescale 1ns/1ns
module vsf_supervisor (
  input  wire logic                  ref_clk,
  input  wire logic                  reset,
  input  wire vsf_pkg::vsf_wb_req_s  wb_req,
  output logic [31:0]                wb_dat_o,
  output logic                       wb_ack_o,
  input  wire logic [3:0]            mon_cmp_raw,
  input  wire logic                  failsafe_enable,
  input  wire logic                  failsafe_init_phase,
  input  wire logic                  core_multiphase,
  input  wire vsf_pkg::vsf_otp_s     otp_cfg,
  output logic                       failsafe_out_n,
  output logic                       reset_out_n,
  output logic                       irq_out,
  output logic [1:0]                 core_buck_off,
  output logic [7:0]                 io_reg_off,
  output logic [7:0]                 core_ov_threshold_code,
  output logic [7:0]                 core_uv_threshold_code,
  output logic [4:0]                 threshold_offset,
  output logic [4:0]                 scaling_offset_out
);

  // All state of this module
  typedef struct packed {
    logic [3:0]                      sync1;
    logic [3:0]                      sync2;
    logic [3:0]                      flt_q;
    logic [7:0]                      impact;
    logic [4:0]                      vsc_off;
    logic [4:0]                      vsc_inv;
    logic [4:0]                      th_off;
    logic [4:0]                      vout_off;
    vsf_pkg::vsf_vsc_e               vsc;
    logic [5:0]                      tick_cnt;
    logic [vsf_pkg::IRQ_W-1:0]       irq_stat;
    logic [vsf_pkg::IRQ_W-1:0]       irq_mask;
    logic                            ack;
    logic [31:0]                     rdata;
    logic                            fs_n;
    logic                            rst_n;
    logic                            irq;
    logic [1:0]                      core_off;
    logic [7:0]                      io_off;
    logic [7:0]                      ov_th;
    logic [7:0]                      uv_th;
  } vsf_state_s;

  vsf_state_s s_reg;
  vsf_state_s s_next;

  logic [3:0]  flt;
  logic [3:0]  fs_req;
  logic [3:0]  rst_req;
  logic [11:0] lim [vsf_pkg::MON_N];

  // Filter lengths picked by the programmed selects
  // core OV filter
  assign lim[vsf_pkg::MON_CORE_OV] = otp_cfg.core_ov_filter_sel ?
                                     vsf_pkg::OV_B_CYC :
                                     vsf_pkg::OV_A_CYC;
  assign lim[vsf_pkg::MON_CORE_UV] =
    vsf_pkg::vsf_uv_cyc(otp_cfg.core_uv_filter_sel);
  assign lim[vsf_pkg::MON_IO_OV]   = otp_cfg.io_ov_filter_sel ?
                                     vsf_pkg::OV_B_CYC :
                                     vsf_pkg::OV_A_CYC;
  assign lim[vsf_pkg::MON_IO_UV]   =
    vsf_pkg::vsf_uv_cyc(otp_cfg.io_uv_filter_sel);

  // One filter and one impact decode per monitor channel
  genvar gi;
  generate
    for (gi = 0; gi < vsf_pkg::MON_N; gi = gi + 1) begin : g_mon
      vsf_deglitch u_filt (
        .ref_clk  (ref_clk),
        .reset    (reset),
        .enable   (failsafe_enable),
        .level    (s_reg.sync2[gi]),
        .limit    (lim[gi]),
        .filtered (flt[gi])
      );
      assign fs_req[gi]  = flt[gi] &&
                           (s_reg.impact[2*gi +: 2] != 2'h0);
      assign rst_req[gi] = flt[gi] && s_reg.impact[2*gi+1];
    end
  endgenerate

  // Bus request decode; only the word address matters
  logic       acc;
  logic       wr;
  logic       rd;
  logic [7:0] badr;
  logic       wr_lo;
  logic       inv_ok;

  assign acc   = wb_req.cyc && wb_req.stb && !s_reg.ack;
  assign wr    = acc && wb_req.we;
  assign rd    = acc && !wb_req.we;
  assign badr  = {wb_req.adr[7:2], 2'h0};
  assign wr_lo = wr && wb_req.sel[0];

  // complement check, offsets above the table are refused too
  assign inv_ok = (wb_req.dat[4:0] == ~s_reg.vsc_off) &&
                  (s_reg.vsc_off <= vsf_pkg::OFF_MAX);

  // Next-state logic
  always_comb begin
    logic [vsf_pkg::IRQ_W-1:0] set;
    logic [vsf_pkg::IRQ_W-1:0] clr;
    logic                      tick;
    set  = '0;
    clr  = '0;
    tick = 1'b0;
    s_next = s_reg;

    // Comparator levels cross in two flops before the filters
    s_next.sync1 = mon_cmp_raw;
    s_next.sync2 = s_reg.sync1;
    s_next.flt_q = flt;

    // Wishbone answer one cycle after the request, one cycle long
    s_next.ack   = acc;
    s_next.rdata = 32'h0000_0000;

    // Register reads; unmapped words read zero
    if (rd) begin
      case (badr)
        vsf_pkg::REG_IMPACT: begin
          s_next.rdata[7:0] = s_reg.impact;
        end
        vsf_pkg::REG_VSC_OFF: begin
          s_next.rdata[4:0] = s_reg.vsc_off;
        end
        vsf_pkg::REG_VSC_INV: begin
          s_next.rdata[4:0] = s_reg.vsc_inv;
        end
        vsf_pkg::REG_STATUS: begin
          s_next.rdata[3:0] = flt;
          s_next.rdata[vsf_pkg::ST_BUSY] =
            (s_reg.vsc == vsf_pkg::VSF_VSC_RAMP);
          s_next.rdata[vsf_pkg::ST_INIT] = failsafe_init_phase;
          s_next.rdata[vsf_pkg::ST_EN]   = failsafe_enable;
          s_next.rdata[vsf_pkg::ST_VOUT +: 5] = s_reg.vout_off;
          s_next.rdata[vsf_pkg::ST_TH +: 5]   = s_reg.th_off;
        end
        vsf_pkg::REG_IRQ_ST: begin
          s_next.rdata[vsf_pkg::IRQ_W-1:0] = s_reg.irq_stat;
        end
        vsf_pkg::REG_IRQ_MSK: begin
          s_next.rdata[vsf_pkg::IRQ_W-1:0] = s_reg.irq_mask;
        end
        default: begin
          s_next.rdata = 32'h0000_0000;
        end
      endcase
    end

    // Register writes; all writable fields sit in byte lane 0
    if (wr_lo) begin
      case (badr)
        vsf_pkg::REG_IMPACT: begin
          if (failsafe_init_phase) begin
            s_next.impact = wb_req.dat[7:0];
          end
        end
        vsf_pkg::REG_VSC_OFF: begin
          if (failsafe_init_phase &&
              s_reg.vsc == vsf_pkg::VSF_VSC_IDLE) begin
            s_next.vsc_off = wb_req.dat[4:0];
          end
        end
        vsf_pkg::REG_VSC_INV: begin
          if (failsafe_init_phase &&
              s_reg.vsc == vsf_pkg::VSF_VSC_IDLE) begin
            s_next.vsc_inv = wb_req.dat[4:0];
            if (inv_ok) begin
              s_next.th_off   = s_reg.vsc_off;
              s_next.vsc      = vsf_pkg::VSF_VSC_RAMP;
              s_next.tick_cnt = 6'h00;
            end else begin
              set[vsf_pkg::IRQ_REJ] = 1'b1;
            end
          end
        end
        vsf_pkg::REG_IRQ_ST: begin
          clr = wb_req.dat[vsf_pkg::IRQ_W-1:0];
        end
        vsf_pkg::REG_IRQ_MSK: begin
          s_next.irq_mask = wb_req.dat[vsf_pkg::IRQ_W-1:0];
        end
        default: begin
          s_next.irq_mask = s_reg.irq_mask;
        end
      endcase
    end

    // Scaling ramp, one 6.25 mV count per step period.
    // Sixteen steps take well under the shortest OV filter time.
    case (s_reg.vsc)
      vsf_pkg::VSF_VSC_IDLE: begin
        s_next.tick_cnt = 6'h00;
      end
      vsf_pkg::VSF_VSC_RAMP: begin
        tick = (s_reg.tick_cnt == vsf_pkg::RAMP_CYC - 6'h01);
        s_next.tick_cnt = tick ? 6'h00 : s_reg.tick_cnt + 6'h01;
        if (tick) begin
          if (s_reg.vout_off < s_reg.th_off) begin
            s_next.vout_off = s_reg.vout_off + 5'h01;
          end else if (s_reg.vout_off > s_reg.th_off) begin
            s_next.vout_off = s_reg.vout_off - 5'h01;
          end
          if (s_next.vout_off == s_reg.th_off) begin
            s_next.vsc = vsf_pkg::VSF_VSC_IDLE;
            set[vsf_pkg::IRQ_DONE] = 1'b1;
          end
        end
      end
      default: begin
        s_next.vsc = vsf_pkg::VSF_VSC_IDLE;
      end
    endcase

    // Sticky events: a fault newly recognised on any channel
    set[3:0] = flt & ~s_reg.flt_q;

    // Set beats a clear in the same cycle, so no event is lost
    s_next.irq_stat = (s_reg.irq_stat & ~clr) | set;
    s_next.irq      = |(s_next.irq_stat & s_next.irq_mask);

    s_next.fs_n  = ~|fs_req;
    s_next.rst_n = ~|rst_req;

    s_next.core_off[0] = flt[vsf_pkg::MON_CORE_OV];
    s_next.core_off[1] = flt[vsf_pkg::MON_CORE_OV] && core_multiphase;

    s_next.io_off = 8'h00;
    if (otp_cfg.io_monitor_source_sel != vsf_pkg::IO_SRC_EXT) begin
      s_next.io_off[otp_cfg.io_monitor_source_sel] =
        flt[vsf_pkg::MON_IO_OV];
    end

    s_next.ov_th = otp_cfg.core_ov_threshold_code;
    s_next.uv_th = otp_cfg.core_uv_threshold_code;
  end

  // State register; outputs start inactive after reset
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      s_reg          <= '0;
      s_reg.impact   <= vsf_pkg::IMPACT_RST;
      s_reg.vsc_off  <= vsf_pkg::OFF_RST;
      s_reg.vsc_inv  <= vsf_pkg::INV_RST;
      s_reg.th_off   <= vsf_pkg::OFF_RST;
      s_reg.vout_off <= vsf_pkg::OFF_RST;
      s_reg.vsc      <= vsf_pkg::VSF_VSC_IDLE;
      s_reg.fs_n     <= 1'b1;
      s_reg.rst_n    <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs straight from the state register
  assign wb_dat_o               = s_reg.rdata;
  assign wb_ack_o               = s_reg.ack;
  assign failsafe_out_n         = s_reg.fs_n;
  assign reset_out_n            = s_reg.rst_n;
  assign irq_out                = s_reg.irq;
  assign core_buck_off          = s_reg.core_off;
  assign io_reg_off             = s_reg.io_off;
  assign core_ov_threshold_code = s_reg.ov_th;
  assign core_uv_threshold_code = s_reg.uv_th;
  assign threshold_offset       = s_reg.th_off;
  assign scaling_offset_out     = s_reg.vout_off;

endmodule

/* File: tb/vsf_supervisor_chk.sv */
// Port checker for the voltage supervisor.
// Bound to vsf_supervisor by the bench; one ref_clk domain.
`timescale 1ns/1ns
module vsf_supervisor_chk (
  input wire logic                 ref_clk,
  input wire logic                 reset,
  input wire vsf_pkg::vsf_wb_req_s wb_req,
  input wire logic                 wb_ack_o,
  input wire logic [3:0]           mon_cmp_raw,
  input wire logic                 failsafe_enable,
  input wire logic                 core_multiphase,
  input wire vsf_pkg::vsf_otp_s    otp_cfg,
  input wire logic                 failsafe_out_n,
  input wire logic                 reset_out_n,
  input wire logic [1:0]           core_buck_off,
  input wire logic [7:0]           io_reg_off,
  input wire logic [7:0]           core_ov_threshold_code,
  input wire logic [4:0]           threshold_offset,
  input wire logic [4:0]           scaling_offset_out
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  logic [11:0] ov_run;
  logic [11:0] ov_lim;
  // Filter length picked by the one-bit select
  assign ov_lim = otp_cfg.core_ov_filter_sel ? vsf_pkg::OV_B_CYC
                                             : vsf_pkg::OV_A_CYC;
  // Enabled overvoltage run length; saturates so it never wraps
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ov_run <= 12'h000;
    end else if (!(mon_cmp_raw[0] && failsafe_enable)) begin
      ov_run <= 12'h000;
    end else if (ov_run != 12'hfff) begin
      ov_run <= ov_run + 12'h001;
    end
  end
  a_ack_one_cycle: assert property (
    wb_req.cyc && wb_req.stb && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus ack not a single cycle after request");
  a_disabled_quiet: assert property (
    !failsafe_enable [*4] |-> failsafe_out_n && reset_out_n
      && core_buck_off == 2'h0 && io_reg_off == 8'h00)
    else $error("reaction while supervision disabled");
  a_ov_not_early: assert property (
    $rose(core_buck_off[0]) |-> ov_run >= ov_lim)
    else $error("core overvoltage acted before its filter time");
  a_ov_not_late: assert property (
    ov_run == ov_lim + 12'h008 |-> core_buck_off[0])
    else $error("core buck not switched off on overvoltage");
  a_buck_off_clears: assert property (
    !mon_cmp_raw[0] [*6] |-> !core_buck_off[0])
    else $error("core buck kept off after fault cleared");
  a_buck_two: assert property (
    core_buck_off[0] && $stable(core_multiphase)
      |-> core_buck_off[1] == core_multiphase)
    else $error("buck two off state wrong for phase mode");
  a_reset_with_fs: assert property (
    !reset_out_n |-> !failsafe_out_n)
    else $error("reset asserted without fail-safe output");
  a_io_src_only: assert property (
    io_reg_off == 8'h00
      || (otp_cfg.io_monitor_source_sel != vsf_pkg::IO_SRC_EXT
      && io_reg_off == 8'h01 << otp_cfg.io_monitor_source_sel))
    else $error("wrong io regulator switched off");
  a_thr_copy: assert property (
    !$past(reset) |->
      core_ov_threshold_code == $past(otp_cfg.core_ov_threshold_code))
    else $error("overvoltage threshold code not the programmed one");
  a_thr_on_ack: assert property (
    $changed(threshold_offset) |-> wb_ack_o)
    else $error("threshold offset moved outside a bus answer");
  a_ramp_step: assert property (
    $changed(scaling_offset_out) |->
      scaling_offset_out - $past(scaling_offset_out) == 5'h01
      || $past(scaling_offset_out) - scaling_offset_out == 5'h01)
    else $error("output offset jumped more than one count");
  a_ramp_bound: assert property (
    $changed(threshold_offset) |->
      ##[1:1000] scaling_offset_out == threshold_offset)
    else $error("voltage ramp did not finish in time");
  c_core_ov: cover property ($rose(core_buck_off[0]));
  c_reset_out: cover property ($fell(reset_out_n));
  c_ramp: cover property ($changed(threshold_offset));
endmodule

/* File: tb/vsf_rail_model.sv */
// Comparator side of the monitored rails.
// Faults are commanded by the bench; edges land off the clock edge,
// as the analog comparators are not tied to ref_clk.
`timescale 1ns/1ns
module vsf_rail_model (
  input  wire logic [3:0] fault_req,
  output logic [3:0]      mon_cmp_raw
);
  // Fixed comparator delay keeps edges away from sampling
  initial mon_cmp_raw = 4'h0;
  always @(fault_req) begin
    mon_cmp_raw <= #7 fault_req;
  end
endmodule

/* File: tb/tb.sv */
// Self-checking bench of the voltage supervisor.
// Host side is driven by Wishbone tasks; rails by vsf_rail_model.
`timescale 1ns/1ns
module tb;
  logic                 ref_clk;
  logic                 reset;
  logic                 failsafe_enable;
  logic                 failsafe_init_phase;
  logic                 core_multiphase;
  logic                 wb_ack_o;
  logic                 irq_out;
  logic                 failsafe_out_n;
  logic                 reset_out_n;
  vsf_pkg::vsf_wb_req_s wb_req;
  vsf_pkg::vsf_otp_s    otp_cfg;
  logic [3:0]           fault_req;
  logic [3:0]           mon_cmp_raw;
  logic [31:0]          wb_dat_o;
  logic [31:0]          rd;
  logic [1:0]           core_buck_off;
  logic [7:0]           io_reg_off;
  logic [7:0]           core_ov_threshold_code;
  logic [7:0]           core_uv_threshold_code;
  logic [4:0]           threshold_offset;
  logic [4:0]           scaling_offset_out;
  int                   fail_count;
  int                   checked;
  int                   uv_t[4] = '{250, 750, 1250, 2000};

  vsf_supervisor dut (
    .ref_clk(ref_clk), .reset(reset), .wb_req(wb_req),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .mon_cmp_raw(mon_cmp_raw), .failsafe_enable(failsafe_enable),
    .failsafe_init_phase(failsafe_init_phase),
    .core_multiphase(core_multiphase), .otp_cfg(otp_cfg),
    .failsafe_out_n(failsafe_out_n), .reset_out_n(reset_out_n),
    .irq_out(irq_out), .core_buck_off(core_buck_off),
    .io_reg_off(io_reg_off),
    .core_ov_threshold_code(core_ov_threshold_code),
    .core_uv_threshold_code(core_uv_threshold_code),
    .threshold_offset(threshold_offset),
    .scaling_offset_out(scaling_offset_out));
  vsf_rail_model u_rail (.fault_req(fault_req), .mon_cmp_raw(mon_cmp_raw));

  // 50 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  task automatic give_verdict();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic bail();
    fail_count++;
    $display("unexpected at %0t: wait ran out", $time);
    give_verdict();
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // One classic cycle; request held until ack is seen, then one idle
  task automatic wb(input logic we, input logic [7:0] a,
                    input logic [31:0] d);
    int n;
    n = 0;
    wb_req <= '{1'b1, 1'b1, we, a, 4'hf, d};
    do begin
      @(posedge ref_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 16);
    if (n >= 16) bail();
    rd = wb_dat_o;
    wb_req <= '0;
    @(posedge ref_clk);
  endtask

  function automatic logic [11:0] pins();
    return {io_reg_off, core_buck_off, failsafe_out_n, reset_out_n};
  endfunction

  task automatic t_reset_values();
    wb(1'b0, vsf_pkg::REG_IMPACT, 32'h0);
    check(rd, 32'h66);
    wb(1'b0, vsf_pkg::REG_VSC_INV, 32'h0);
    check(rd, 32'h1f);
    wb(1'b1, 8'h18, 32'hffffffff);
    wb(1'b0, 8'h18, 32'h0);
    check(rd, 32'h0);
    check(core_ov_threshold_code, 8'h5a);
    check(core_uv_threshold_code, 8'h21);
  endtask

  // Settings outside the init phase must be ignored
  task automatic t_init_gate();
    failsafe_init_phase <= 1'b0;
    wb(1'b1, vsf_pkg::REG_IMPACT, 32'h0);
    wb(1'b0, vsf_pkg::REG_IMPACT, 32'h0);
    check(rd, 32'h66);
    wb(1'b1, vsf_pkg::REG_VSC_OFF, 32'h3);
    wb(1'b0, vsf_pkg::REG_VSC_OFF, 32'h0);
    check(rd, 32'h0);
    failsafe_init_phase <= 1'b1;
  endtask

  task automatic t_disabled();
    fault_req <= 4'hf;
    tick(1300);
    check(pins(), 12'h003);
    wb(1'b0, vsf_pkg::REG_STATUS, 32'h0);
    check(rd[3:0], 4'h0);
    fault_req <= 4'h0;
    failsafe_enable <= 1'b1;
    tick(8);
  endtask

  // Good scaling, then the done interrupt masked, raised, cleared
  task automatic t_vsc_good();
    int n;
    wb(1'b1, vsf_pkg::REG_VSC_OFF, 32'h10);
    tick(60);
    check(scaling_offset_out, 5'h00);
    wb(1'b1, vsf_pkg::REG_VSC_INV, 32'h0f);
    check(threshold_offset, 5'h10);
    // Busy, init, enable, output still 0, target 16
    wb(1'b0, vsf_pkg::REG_STATUS, 32'h0);
    check(rd & 32'h001f_1f70, 32'h0010_0070);
    n = 0;
    while (scaling_offset_out !== 5'h10 && n < 1250) begin
      tick(1);
      n++;
    end
    if (n >= 1250) bail();
    check(irq_out, 1'b0);
    wb(1'b1, vsf_pkg::REG_IRQ_MSK, 32'h10);
    check(irq_out, 1'b1);
    wb(1'b0, vsf_pkg::REG_IRQ_ST, 32'h0);
    check(rd & 32'h30, 32'h10);
    wb(1'b1, vsf_pkg::REG_IRQ_ST, 32'h10);
    tick(2);
    check(irq_out, 1'b0);
  endtask

  task automatic t_vsc_bad();
    wb(1'b1, vsf_pkg::REG_VSC_OFF, 32'h03);
    wb(1'b1, vsf_pkg::REG_VSC_INV, 32'h1b);
    wb(1'b1, vsf_pkg::REG_VSC_OFF, 32'h11);
    wb(1'b1, vsf_pkg::REG_VSC_INV, 32'h0e);
    tick(120);
    check({threshold_offset, scaling_offset_out}, 10'h210);
    wb(1'b0, vsf_pkg::REG_IRQ_ST, 32'h0);
    check(rd & 32'h20, 32'h20);
  endtask

  // Every impact code and filter select on every channel
  task automatic t_impact();
    logic [1:0]  c;
    logic [11:0] e;
    int          lim;
    for (int ch = 0; ch < 4; ch++) begin
      for (int k = 0; k < 4; k++) begin
        c = 2'(k);
        lim = ch[0] ? uv_t[k] : (c[0] ? 2250 : 1250);
        core_multiphase <= c[0];
        otp_cfg.core_ov_filter_sel <= c[0];
        otp_cfg.io_ov_filter_sel <= c[0];
        otp_cfg.core_uv_filter_sel <= c;
        otp_cfg.io_uv_filter_sel <= c;
        otp_cfg.io_monitor_source_sel <= c[0] ? 3'h3 : 3'h0;
        wb(1'b1, vsf_pkg::REG_IMPACT, 32'(k) << (2 * ch));
        fault_req <= 4'h1 << ch;
        tick(lim - 8);
        check(pins(), 12'h003);
        tick(16);
        e = {(ch == 2 && c[0]) ? 8'h08 : 8'h00,
             (ch == 0) ? {c[0], 1'b1} : 2'h0, k == 0, !c[1]};
        check(pins(), e);
        fault_req <= 4'h0;
        tick(8);
        check(pins(), 12'h003);
      end
    end
    wb(1'b1, vsf_pkg::REG_IMPACT, 32'h09);
    fault_req <= 4'h3;
    tick(2300);
    check(pins(), 12'h00c);
    fault_req <= 4'h1;
    tick(8);
    check(pins(), 12'h00d);
    fault_req <= 4'h0;
    // Every channel has reported its recognised fault
    wb(1'b0, vsf_pkg::REG_IRQ_ST, 32'h0);
    check(rd & 32'h0f, 32'h0f);
  endtask

  initial begin
    reset = 1'b1;
    wb_req = '0;
    failsafe_enable = 1'b0;
    failsafe_init_phase = 1'b1;
    core_multiphase = 1'b0;
    fault_req = 4'h0;
    otp_cfg = '{1'b0, 2'h0, 1'b0, 2'h0, 8'h5a, 8'h21, 3'h3};
    fail_count = 0;
    checked = 0;
    tick(2);
    reset <= 1'b0;
    tick(1);
    t_reset_values();
    t_init_gate();
    t_disabled();
    t_vsc_good();
    t_vsc_bad();
    t_impact();
    give_verdict();
  end
endmodule

bind vsf_supervisor vsf_supervisor_chk u_chk (
  .ref_clk(ref_clk), .reset(reset), .wb_req(wb_req),
  .wb_ack_o(wb_ack_o), .mon_cmp_raw(mon_cmp_raw),
  .failsafe_enable(failsafe_enable), .core_multiphase(core_multiphase),
  .otp_cfg(otp_cfg), .failsafe_out_n(failsafe_out_n),
  .reset_out_n(reset_out_n), .core_buck_off(core_buck_off),
  .io_reg_off(io_reg_off),
  .core_ov_threshold_code(core_ov_threshold_code),
  .threshold_offset(threshold_offset),
  .scaling_offset_out(scaling_offset_out));
